// [rwc_pkg.sv]
package rwc_pkg;

    // =====================================================================
    // Register indices (byte address is four times the index)
    localparam int unsigned ADDR_W         = 10;
    localparam logic [7:0]  IDX_PB_OUT     = 8'hd5;
    localparam logic [7:0]  IDX_PB_DIR     = 8'hd6;
    localparam logic [7:0]  IDX_PB_SFR     = 8'hd7;
    localparam logic [7:0]  IDX_INT_REQ    = 8'hfa;
    localparam logic [7:0]  IDX_INT_MASK   = 8'hfb;
    localparam logic [7:0]  IDX_FLAGS      = 8'hfc;
    localparam logic [7:0]  IDX_REG_PTR    = 8'hfd;
    localparam logic [7:0]  IDX_STACK_PTR  = 8'hff;
    localparam logic [7:0]  IDX_TCH        = 8'hf1;

    // =====================================================================
    // Reset values and masks
    localparam logic [7:0]  REG_CLEAR      = 8'h00;
    localparam logic [7:0]  SP_KEEP_MASK   = 8'h3f;
    localparam logic [7:0]  RP_KEEP_MASK   = 8'hf0;
    localparam logic [7:0]  FLAGS_KEEP_MASK = 8'hfc;
    localparam int unsigned FLAG_WDT_BIT   = 0;
    localparam int unsigned FLAG_SMR_BIT   = 1;
    localparam logic [7:0]  TCH_LOCK_MASK  = 8'hf8;
    localparam logic [7:0]  TCH_RESET      = 8'h70;
    localparam int unsigned WTS_LSB        = 4;
    localparam logic [2:0]  WTS_DISABLED   = 3'h0;
    localparam logic [15:0] RESET_VECTOR   = 16'h0020;

    // =====================================================================
    // Timing in crystal clock cycles
    localparam int unsigned START_DELAY_CYCLES = 10;
    localparam int unsigned PIN_HOLD_MIN_CYCLES = 30;
    localparam int unsigned WDT_BASE_CYCLES    = 65536;

    typedef enum logic [1:0] {
        ST_PIN,
        ST_START,
        ST_RUN
    } rwc_state_t;

endpackage : rwc_pkg

// [rwc_top.sv]
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Reset from pin, watchdog or stop recovery
// - Only pin reset restores control registers
// - Reset loads program counter with vector
// - General registers untouched by any reset
// - Execution starts 11 cycles after synchronised pin high
// - Pin reset clears stack pointer top bits
// - Pin reset clears register pointer low nibble
// - Pin reset touches only two flag bits
// - Pin reset clears interrupt mask
// - Pin reset clears interrupt requests
// - Pin reset clears port B special functions
// - Pin reset makes port B all inputs
// - Port B output value survives pin reset
// - Upper timer control bits writable first instruction
// - Later writes to those bits ignored
// - Time select code sets watchdog timeout
// - Time select resets to all ones
module rwc_top #(
    parameter int unsigned WDT_BASE = rwc_pkg::WDT_BASE_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [rwc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Reset pin and core events
    input  wire logic                      reset_pin_n,
    input  wire logic                      instr_done,
    input  wire logic                      wdt_refresh,
    input  wire logic                      stop_recover,
    input  wire logic [7:0]                int_set,
    // Core reset control
    output logic                           cpu_reset_n,
    output logic [15:0]                    reset_vector,
    output logic                           first_instr,
    // Control registers
    output logic [7:0]                     stack_pointer,
    output logic [7:0]                     register_pointer,
    output logic [7:0]                     flags,
    output logic [7:0]                     interrupt_mask,
    output logic [7:0]                     interrupt_request,
    output logic [7:0]                     port_b_output_value,
    output logic [7:0]                     port_b_direction,
    output logic [7:0]                     port_b_special_function,
    output logic [7:0]                     timer_control_high
);

    // =====================================================================
    // Helpers
    function automatic logic [31:0] wdt_limit(input logic [2:0] sel);
        logic [2:0] sh;
        sh = sel - 3'h1;
        wdt_limit = WDT_BASE << sh;
    endfunction : wdt_limit

    function automatic logic idx_known(input logic [7:0] idx);
        unique case (idx)
            rwc_pkg::IDX_PB_OUT, rwc_pkg::IDX_PB_DIR, rwc_pkg::IDX_PB_SFR,
            rwc_pkg::IDX_INT_REQ, rwc_pkg::IDX_INT_MASK, rwc_pkg::IDX_FLAGS,
            rwc_pkg::IDX_REG_PTR, rwc_pkg::IDX_STACK_PTR,
            rwc_pkg::IDX_TCH: idx_known = 1'b1;
            default:          idx_known = 1'b0;
        endcase
    endfunction : idx_known

    // =====================================================================
    // Reset pin synchroniser
    logic                 pin_s1;
    logic                 pin_s2;
    logic                 pin_s3;
    logic                 pin_level;
    logic                 pin_rst;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_s3    <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_s1 <= reset_pin_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
        end
    end

    assign pin_rst = !pin_level;

    // =====================================================================
    // APB access
    logic [7:0]           idx;
    logic                 access;
    logic                 wr_en;
    logic [7:0]           wdat;
    logic [7:0]           rd_val;

    assign idx    = paddr[rwc_pkg::ADDR_W-1:2];
    assign access = psel && penable;
    assign wr_en  = access && pwrite && pready && paddr[1:0] == 2'h0;
    assign wdat   = pwdata[7:0];

    always_comb begin
        unique case (idx)
            rwc_pkg::IDX_PB_OUT:    rd_val = port_b_output_value;
            rwc_pkg::IDX_PB_DIR:    rd_val = port_b_direction;
            rwc_pkg::IDX_PB_SFR:    rd_val = port_b_special_function;
            rwc_pkg::IDX_INT_REQ:   rd_val = interrupt_request;
            rwc_pkg::IDX_INT_MASK:  rd_val = interrupt_mask;
            rwc_pkg::IDX_FLAGS:     rd_val = flags;
            rwc_pkg::IDX_REG_PTR:   rd_val = register_pointer;
            rwc_pkg::IDX_STACK_PTR: rd_val = stack_pointer;
            rwc_pkg::IDX_TCH:       rd_val = timer_control_high;
            default:                rd_val = rwc_pkg::REG_CLEAR;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
                pslverr <= !idx_known(idx) || paddr[1:0] != 2'h0;
            end else begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Reset sequencer
    rwc_pkg::rwc_state_t  state;
    logic [3:0]           start_cnt;
    logic [31:0]          wdt_cnt;
    logic [2:0]           wts;
    logic                 wdt_hit;
    logic                 smr_hit;

    assign wts     = timer_control_high[rwc_pkg::WTS_LSB +: 3];
    assign wdt_hit = state == rwc_pkg::ST_RUN && wts != rwc_pkg::WTS_DISABLED
                     && wdt_cnt == wdt_limit(wts) - 32'h0000_0001;
    assign smr_hit = state == rwc_pkg::ST_RUN && stop_recover;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= rwc_pkg::ST_PIN;
            start_cnt   <= 4'h0;
            cpu_reset_n <= 1'b0;
            first_instr <= 1'b0;
        end else if (pin_rst) begin
            state       <= rwc_pkg::ST_PIN;
            start_cnt   <= 4'h0;
            cpu_reset_n <= 1'b0;
            first_instr <= 1'b0;
        end else begin
            unique case (state)
                rwc_pkg::ST_PIN: begin
                    state     <= rwc_pkg::ST_START;
                    start_cnt <= 4'h0;
                end
                rwc_pkg::ST_START: begin
                    if (start_cnt == 4'(rwc_pkg::START_DELAY_CYCLES - 1)) begin
                        state       <= rwc_pkg::ST_RUN;
                        cpu_reset_n <= 1'b1;
                        first_instr <= 1'b1;
                    end else begin
                        start_cnt <= start_cnt + 4'h1;
                    end
                end
                rwc_pkg::ST_RUN: begin
                    if (wdt_hit || smr_hit) begin
                        state       <= rwc_pkg::ST_START;
                        start_cnt   <= 4'h0;
                        cpu_reset_n <= 1'b0;
                        first_instr <= 1'b0;
                    end else if (instr_done) begin
                        first_instr <= 1'b0;
                    end
                end
            endcase
        end
    end

    // vector presented while core held in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_vector <= rwc_pkg::RESET_VECTOR;
        end else begin
            reset_vector <= rwc_pkg::RESET_VECTOR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt <= 32'h0000_0000;
        end else if (state != rwc_pkg::ST_RUN || wdt_hit || wdt_refresh) begin
            wdt_cnt <= 32'h0000_0000;
        end else if (wts != rwc_pkg::WTS_DISABLED) begin
            wdt_cnt <= wdt_cnt + 32'h0000_0001;
        end
    end

    // =====================================================================
    // Control registers
    // no general-purpose storage is reset here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            stack_pointer <= stack_pointer & rwc_pkg::SP_KEEP_MASK;
        end else if (wr_en && idx == rwc_pkg::IDX_STACK_PTR) begin
            stack_pointer <= wdat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            register_pointer <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            register_pointer <= register_pointer & rwc_pkg::RP_KEEP_MASK;
        end else if (wr_en && idx == rwc_pkg::IDX_REG_PTR) begin
            register_pointer <= wdat;
        end
    end

    // cause flags, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            flags <= flags & rwc_pkg::FLAGS_KEEP_MASK;
        end else begin
            if (wr_en && idx == rwc_pkg::IDX_FLAGS) begin
                flags[7:2] <= wdat[7:2];
                flags[1:0] <= (flags[1:0] & ~wdat[1:0]) | {smr_hit, wdt_hit};
            end else begin
                flags[1:0] <= flags[1:0] | {smr_hit, wdt_hit};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            interrupt_mask <= rwc_pkg::REG_CLEAR;
        end else if (wr_en && idx == rwc_pkg::IDX_INT_MASK) begin
            interrupt_mask <= wdat;
        end
    end

    // interrupt requests cleared, source set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            interrupt_request <= rwc_pkg::REG_CLEAR;
        end else if (wr_en && idx == rwc_pkg::IDX_INT_REQ) begin
            interrupt_request <= wdat | int_set;
        end else begin
            interrupt_request <= interrupt_request | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_special_function <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            port_b_special_function <= rwc_pkg::REG_CLEAR;
        end else if (wr_en && idx == rwc_pkg::IDX_PB_SFR) begin
            port_b_special_function <= wdat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_direction <= rwc_pkg::REG_CLEAR;
        end else if (pin_rst) begin
            port_b_direction <= rwc_pkg::REG_CLEAR;
        end else if (wr_en && idx == rwc_pkg::IDX_PB_DIR) begin
            port_b_direction <= wdat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_output_value <= rwc_pkg::REG_CLEAR;
        end else if (!pin_rst && wr_en && idx == rwc_pkg::IDX_PB_OUT) begin
            port_b_output_value <= wdat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_high <= rwc_pkg::TCH_RESET;
        end else if (pin_rst) begin
            timer_control_high <= rwc_pkg::TCH_RESET;
        end else if (wr_en && idx == rwc_pkg::IDX_TCH) begin
            if (first_instr) begin
                timer_control_high <= wdat;
            end else begin
                timer_control_high <= (timer_control_high & rwc_pkg::TCH_LOCK_MASK)
                                      | (wdat & ~rwc_pkg::TCH_LOCK_MASK);
            end
        end
    end

    // =====================================================================
    // Checks
    start_delay_a : assert property (@(posedge pclk) disable iff (!presetn)
        (state == rwc_pkg::ST_PIN && pin_level)
        |-> !cpu_reset_n ##10 !cpu_reset_n ##1 cpu_reset_n)
        else $error("core released at wrong cycle after pin");
    sp_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> stack_pointer[7:6] == 2'h0
                    && stack_pointer[5:0] == $past(stack_pointer[5:0]))
        else $error("stack pointer wrong after pin reset");
    rp_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> register_pointer[3:0] == 4'h0
                    && register_pointer[7:4] == $past(register_pointer[7:4]))
        else $error("register pointer wrong after pin reset");
    flags_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> flags[7:2] == $past(flags[7:2]))
        else $error("upper flags changed by pin reset");
    mask_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> interrupt_mask == 8'h00)
        else $error("interrupt mask not cleared");
    req_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> interrupt_request == 8'h00)
        else $error("interrupt request not cleared");
    sfr_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> port_b_special_function == 8'h00)
        else $error("special function not cleared");
    dir_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> port_b_direction == 8'h00)
        else $error("direction not cleared");
    pbout_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> $stable(port_b_output_value))
        else $error("port output value changed in pin reset");
    tch_lock_a : assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == rwc_pkg::IDX_TCH && !first_instr && !pin_rst)
        |=> timer_control_high[7:3] == $past(timer_control_high[7:3]))
        else $error("locked timer control bits written");
    tch_default_a : assert property (@(posedge pclk) disable iff (!presetn)
        pin_rst |=> timer_control_high[6:4] == 3'h7)
        else $error("time select not all ones after reset");
    wdt_trip_a : assert property (@(posedge pclk) disable iff (!presetn)
        wdt_hit |=> flags[0] && !cpu_reset_n && wdt_cnt == 32'h0000_0000)
        else $error("watchdog timeout did not reset");
    smr_reset_a : assert property (@(posedge pclk) disable iff (!presetn)
        smr_hit && !pin_rst |=> flags[1] && !cpu_reset_n
                                && state == rwc_pkg::ST_START)
        else $error("stop recovery did not reset");
    keep_regs_a : assert property (@(posedge pclk) disable iff (!presetn)
        (wdt_hit && !pin_rst && !wr_en) |=> $stable(port_b_direction)
                                            && $stable(interrupt_mask))
        else $error("control registers changed by watchdog reset");

endmodule : rwc_top
`default_nettype wire

// [rwc_pin_driver.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// External reset circuit, pin pulled up when idle
module rwc_pin_driver #(
    parameter int unsigned SETTLE = 5,
    parameter int unsigned HOLD   = 30
) (
    // Clock and request
    input  wire logic pclk,
    input  wire logic press,
    // Reset pin
    output logic      reset_pin_n
);
    int unsigned cnt = 0;

    always_ff @(posedge pclk) begin
        if (press) begin
            cnt <= SETTLE + HOLD;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    assign reset_pin_n = (cnt == 0);
endmodule : rwc_pin_driver
`default_nettype wire

// [reset_and_watchdog_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module reset_and_watchdog_control_tb;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] after;
    } rwc_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reset_pin_n;
    logic        press;
    logic        instr_done;
    logic        wdt_refresh;
    logic        stop_recover;
    logic [7:0]  int_set;
    logic        cpu_reset_n;
    logic [15:0] reset_vector;
    logic        first_instr;
    logic [7:0]  sp, rp, fl, im, ir, pbo, pbd, pbs, tch;
    logic [7:0]  rd;
    logic        err;
    int          mismatches = 0;
    int          n_tests = 0;
    int          run_cyc = 0;
    int          n;
    // Write value and value expected after a pin reset
    rwc_row_t    rows [8] = '{
        '{rwc_pkg::IDX_STACK_PTR, 8'hff, 8'h3f},
        '{rwc_pkg::IDX_REG_PTR,   8'hff, 8'hf0},
        '{rwc_pkg::IDX_FLAGS,     8'hf0, 8'hf0},
        '{rwc_pkg::IDX_INT_MASK,  8'ha5, 8'h00},
        '{rwc_pkg::IDX_INT_REQ,   8'h5a, 8'h00},
        '{rwc_pkg::IDX_PB_SFR,    8'h99, 8'h00},
        '{rwc_pkg::IDX_PB_DIR,    8'hc3, 8'h00},
        '{rwc_pkg::IDX_PB_OUT,    8'h3c, 8'h3c}};

    rwc_top #(.WDT_BASE(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .instr_done(instr_done), .wdt_refresh(wdt_refresh),
        .stop_recover(stop_recover), .int_set(int_set), .cpu_reset_n(cpu_reset_n),
        .reset_vector(reset_vector), .first_instr(first_instr), .stack_pointer(sp),
        .register_pointer(rp), .flags(fl), .interrupt_mask(im),
        .interrupt_request(ir), .port_b_output_value(pbo), .port_b_direction(pbd),
        .port_b_special_function(pbs), .timer_control_high(tch));

    rwc_pin_driver pin (.pclk(pclk), .press(press), .reset_pin_n(reset_pin_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Cycles the core has been running
    always @(posedge pclk) run_cyc <= (cpu_reset_n === 1'b1) ? run_cyc + 1 : 0;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic timeout(input string what);
        mismatches++;
        $display("MISMATCH %s expected done seen timeout", what);
        stop_test();
    endtask : timeout

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 8) timeout("pready");
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_core(input logic lvl, output int cyc);
        for (cyc = 0; cyc < 300; cyc++) begin
            @(posedge pclk);
            if (cpu_reset_n === lvl) break;
        end
        if (cyc == 300) timeout("core level");
    endtask : wait_core

    task automatic end_instr();
        @(posedge pclk);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        @(posedge pclk);
    endtask : end_instr

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        press = 1'b0;
        instr_done = 1'b0;
        wdt_refresh = 1'b0;
        stop_recover = 1'b0;
        int_set = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("vector", 16'h0020, reset_vector);
        apb(1'b0, rwc_pkg::IDX_TCH, 8'h00);
        chk("tch reset", 8'h70, rd);
        wait_core(1'b1, n);
        end_instr();
        for (int i = 0; i < 8; i++) apb(1'b1, rows[i].idx, rows[i].wd);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, rows[i].idx, 8'h00);
            chk("readback", rows[i].wd, rd);
        end
        apb(1'b0, 8'hfe, 8'h00);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 8'h00, rd);
        $display("test registers done");
        // Pin reset, then start delay
        @(posedge pclk);
        press <= 1'b1;
        @(posedge pclk);
        press <= 1'b0;
        for (n = 0; n < 100; n++) begin
            @(posedge pclk);
            if (reset_pin_n === 1'b1) break;
        end
        if (n == 100) timeout("pin release");
        chk("core held", 1'b0, cpu_reset_n);
        chk("vector", 16'h0020, reset_vector);
        wait_core(1'b1, n);
        chk("start delay", 1'b1, n >= 12 && n <= 16);
        chk("first instr", 1'b1, first_instr);
        apb(1'b1, rwc_pkg::IDX_TCH, 8'h18);
        end_instr();
        chk("first closed", 1'b0, first_instr);
        $display("test pin reset done");
        // Watchdog at code 001
        wait_core(1'b0, n);
        chk("wdt period", 1'b1, run_cyc >= 15 && run_cyc <= 17);
        chk("wdt flag", 1'b1, fl[0]);
        wait_core(1'b1, n);
        chk("hold length", 16'(rwc_pkg::START_DELAY_CYCLES), 16'(n + 1));
        apb(1'b0, rwc_pkg::IDX_TCH, 8'h00);
        chk("tch kept", 8'h18, rd);
        apb(1'b1, rwc_pkg::IDX_TCH, 8'h08);
        end_instr();
        apb(1'b1, rwc_pkg::IDX_TCH, 8'hf8);
        apb(1'b0, rwc_pkg::IDX_TCH, 8'h00);
        chk("tch locked", 8'h08, rd);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, rows[i].idx, 8'h00);
            chk("after resets", rows[i].after | {7'h00, rows[i].idx == rwc_pkg::IDX_FLAGS}, rd);
        end
        @(posedge pclk);
        wdt_refresh <= 1'b1;
        @(posedge pclk);
        wdt_refresh <= 1'b0;
        repeat (2100) @(posedge pclk);
        chk("wdt disabled", 1'b1, cpu_reset_n);
        $display("test watchdog done");
        // Stop-mode recovery
        @(posedge pclk);
        stop_recover <= 1'b1;
        @(posedge pclk);
        stop_recover <= 1'b0;
        wait_core(1'b0, n);
        chk("stop latency", 0, n);
        chk("stop flag", 1'b1, fl[1]);
        wait_core(1'b1, n);
        apb(1'b1, rwc_pkg::IDX_FLAGS, 8'hf3);
        apb(1'b0, rwc_pkg::IDX_FLAGS, 8'h00);
        chk("flags cleared", 8'hf0, rd);
        @(posedge pclk);
        int_set <= 8'h81;
        @(posedge pclk);
        int_set <= 8'h00;
        @(posedge pclk);
        chk("int request", 8'h81, ir);
        $display("test stop recovery done");
        stop_test();
    end
endmodule : reset_and_watchdog_control_tb
`default_nettype wire
